// File: hw/uirp_pkg.sv
/*
 * Constants, internal register map and type definitions shared by the
 * indirect register port of the USB function controller.
 * Assumes the core writes and reads the two special function registers
 * with one-cycle strobes synchronous to ref_clk.
 */
// Functional notes
// RL1 - Core polls busy bit 7 before access
// RL2 - Core loads target select for every read and for the first write to a target
// RL3 - Data port write forwards byte to target
// RL4 - Repeated writes may skip target reload
// RL5 - Busy write starts read; result in data
// RL6 - Event flags at 0x02, 0x04, 0x06
// RL7 - Event enables at 0x07, 0x09, 0x0b
// RL8 - Common registers at 0x00-0x01, 0x0c-0x0f
// RL9 - Indexed registers at 0x11-0x17 decoded
// RL10 - Indexed accesses follow selected endpoint
// RL11 - Busy held until transfer really completes
package uirp_pkg;

   // Indirect address register fields
   localparam int BUSY_BIT = 7;
   localparam int AUTO_READ_BIT = 6;
   localparam int TARGET_MSB = 5;
   localparam logic [7:0] ADDR_REG_RESET = 8'h00;
   localparam logic [7:0] DATA_PORT_RESET = 8'h00;

   // Internal register offsets
   localparam logic [5:0] OFS_FUNCTION_ADDRESS = 6'h00;
   localparam logic [5:0] OFS_POWER_MANAGEMENT = 6'h01;
   localparam logic [5:0] OFS_IN_EVENT_FLAGS = 6'h02;
   localparam logic [5:0] OFS_OUT_EVENT_FLAGS = 6'h04;
   localparam logic [5:0] OFS_COMMON_EVENT_FLAGS = 6'h06;
   localparam logic [5:0] OFS_IN_EVENT_ENABLES = 6'h07;
   localparam logic [5:0] OFS_OUT_EVENT_ENABLES = 6'h09;
   localparam logic [5:0] OFS_COMMON_EVENT_ENABLES = 6'h0b;
   localparam logic [5:0] OFS_FRAME_NUMBER_LOW = 6'h0c;
   localparam logic [5:0] OFS_FRAME_NUMBER_HIGH = 6'h0d;
   localparam logic [5:0] OFS_ENDPOINT_SELECT = 6'h0e;
   localparam logic [5:0] OFS_CLOCK_RECOVERY = 6'h0f;
   localparam logic [5:0] OFS_EP_CSR_LOW = 6'h11;
   localparam logic [5:0] OFS_EP_IN_CSR_HIGH = 6'h12;
   localparam logic [5:0] OFS_EP_OUT_CSR_LOW = 6'h14;
   localparam logic [5:0] OFS_EP_OUT_CSR_HIGH = 6'h15;
   localparam logic [5:0] OFS_EP_COUNT_LOW = 6'h16;
   localparam logic [5:0] OFS_EP_OUT_COUNT_HIGH = 6'h17;
   localparam logic [5:0] OFS_QUEUE_BASE = 6'h20;
   localparam logic [3:0] QUEUE_PAGE = 4'h8;

   // Reset values
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] CLOCK_RECOVERY_RESET = 8'h09;

   // Cycles an internal access takes before it completes
   localparam int ACCESS_LATENCY = 2;

   typedef enum logic [4:0] {
      SEL_NONE, SEL_FUNCTION_ADDRESS_REG, SEL_POWER, SEL_IN_FLAGS, SEL_OUT_FLAGS, SEL_CM_FLAGS,
      SEL_IN_EN, SEL_OUT_EN, SEL_CM_EN, SEL_FRAME_LO, SEL_FRAME_HI, SEL_EP_SELECT,
      SEL_CLOCK_RECOVERY_CONTROL, SEL_QUEUE, SEL_EP0_CSR, SEL_IN_CSR_LO, SEL_IN_CSR_HI,
      SEL_OUT_CSR_LO, SEL_OUT_CSR_HI, SEL_EP0_COUNT, SEL_OUT_COUNT_LO,
      SEL_OUT_COUNT_HI
   } uirp_sel_e;

   typedef enum logic [1:0] {
      ST_IDLE, ST_WRITE, ST_READ
   } uirp_state_e;

endpackage

// File: hw/uirp_decode.sv
/*
 * Combinational decoder of the internal register map.
 * Assumes the endpoint number comes from the endpoint select register.
 */
`timescale 1ns/1ps
module uirp_decode (
   input wire logic [5:0] addr,
   input wire logic [1:0] ep_num,
   output uirp_pkg::uirp_sel_e sel
);
   always_comb begin
      sel = uirp_pkg::SEL_NONE;
      if (addr[5:2] == uirp_pkg::QUEUE_PAGE) begin
         sel = uirp_pkg::SEL_QUEUE;
      end
      else begin
         case (addr)
            // RL8 common register map
            uirp_pkg::OFS_FUNCTION_ADDRESS: sel = uirp_pkg::SEL_FUNCTION_ADDRESS_REG;
            uirp_pkg::OFS_POWER_MANAGEMENT: sel = uirp_pkg::SEL_POWER;
            uirp_pkg::OFS_FRAME_NUMBER_LOW: sel = uirp_pkg::SEL_FRAME_LO;
            uirp_pkg::OFS_FRAME_NUMBER_HIGH: sel = uirp_pkg::SEL_FRAME_HI;
            uirp_pkg::OFS_ENDPOINT_SELECT: sel = uirp_pkg::SEL_EP_SELECT;
            uirp_pkg::OFS_CLOCK_RECOVERY: sel = uirp_pkg::SEL_CLOCK_RECOVERY_CONTROL;
            // RL6 event flag map
            uirp_pkg::OFS_IN_EVENT_FLAGS: sel = uirp_pkg::SEL_IN_FLAGS;
            uirp_pkg::OFS_OUT_EVENT_FLAGS: sel = uirp_pkg::SEL_OUT_FLAGS;
            uirp_pkg::OFS_COMMON_EVENT_FLAGS: sel = uirp_pkg::SEL_CM_FLAGS;
            // RL7 event enable map
            uirp_pkg::OFS_IN_EVENT_ENABLES: sel = uirp_pkg::SEL_IN_EN;
            uirp_pkg::OFS_OUT_EVENT_ENABLES: sel = uirp_pkg::SEL_OUT_EN;
            uirp_pkg::OFS_COMMON_EVENT_ENABLES: sel = uirp_pkg::SEL_CM_EN;
            // RL9 RL10 indexed map, endpoint 0 shares low addresses
            uirp_pkg::OFS_EP_CSR_LOW: begin
               sel = (ep_num == 2'd0) ? uirp_pkg::SEL_EP0_CSR : uirp_pkg::SEL_IN_CSR_LO;
            end
            uirp_pkg::OFS_EP_COUNT_LOW: begin
               sel = (ep_num == 2'd0) ? uirp_pkg::SEL_EP0_COUNT : uirp_pkg::SEL_OUT_COUNT_LO;
            end
            uirp_pkg::OFS_EP_IN_CSR_HIGH: begin
               sel = (ep_num == 2'd0) ? uirp_pkg::SEL_NONE : uirp_pkg::SEL_IN_CSR_HI;
            end
            uirp_pkg::OFS_EP_OUT_CSR_LOW: begin
               sel = (ep_num == 2'd0) ? uirp_pkg::SEL_NONE : uirp_pkg::SEL_OUT_CSR_LO;
            end
            uirp_pkg::OFS_EP_OUT_CSR_HIGH: begin
               sel = (ep_num == 2'd0) ? uirp_pkg::SEL_NONE : uirp_pkg::SEL_OUT_CSR_HI;
            end
            uirp_pkg::OFS_EP_OUT_COUNT_HIGH: begin
               sel = (ep_num == 2'd0) ? uirp_pkg::SEL_NONE : uirp_pkg::SEL_OUT_COUNT_HI;
            end
            default: sel = uirp_pkg::SEL_NONE;
         endcase
      end
   end
endmodule

// File: hw/uirp_reg_file.sv
/*
 * Internal register file behind the indirect port: storage of the
 * writable registers, status read-back and endpoint queue strobes.
 * Assumes one request at a time; a new request only after ack.
 */
`timescale 1ns/1ps
module uirp_reg_file #(
   parameter int LATENCY = uirp_pkg::ACCESS_LATENCY
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic req,
   input wire logic we,
   input wire logic [5:0] addr,
   input wire logic [7:0] wdata,
   output logic ack,
   output logic [7:0] rdata_reg,
   input wire logic [7:0] in_flags,
   input wire logic [7:0] out_flags,
   input wire logic [7:0] common_flags,
   input wire logic [7:0] frame_low,
   input wire logic [7:0] frame_high,
   input wire logic [31:0] count_low_all,
   input wire logic [31:0] count_high_all,
   input wire logic [7:0] queue_rdata,
   output logic [7:0] function_address_reg,
   output logic [7:0] power_management_reg,
   output logic [7:0] in_enables_reg,
   output logic [7:0] out_enables_reg,
   output logic [7:0] common_enables_reg,
   output logic [7:0] endpoint_select_reg,
   output logic [7:0] clock_recovery_reg,
   output logic [7:0] ep_zero_csr_reg,
   output logic [31:0] in_csr_low_all,
   output logic [31:0] in_csr_high_all,
   output logic [31:0] out_csr_low_all,
   output logic [31:0] out_csr_high_all,
   output logic queue_write,
   output logic queue_read,
   output logic [1:0] queue_ep,
   output logic [7:0] queue_wdata
);
   localparam logic [3:0] LAT = 4'(LATENCY);

   logic [3:0] wait_reg;
   logic busy_reg;
   logic we_reg;
   logic [5:0] addr_reg;
   logic [7:0] wdata_reg;
   logic [7:0] in_lo_reg [4];
   logic [7:0] in_hi_reg [4];
   logic [7:0] out_lo_reg [4];
   logic [7:0] out_hi_reg [4];
   logic [1:0] ep;
   logic done;
   uirp_pkg::uirp_sel_e sel;

   assign ep = endpoint_select_reg[1:0];
   assign done = busy_reg && (wait_reg == 4'h1);
   assign ack = done;

   uirp_decode u_decode (
      .addr(addr_reg),
      .ep_num(ep),
      .sel(sel)
   );

   // Access latency stands in for the crossing into the USB core
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         busy_reg <= 1'b0;
         wait_reg <= 4'h0;
         we_reg <= 1'b0;
         addr_reg <= 6'h00;
         wdata_reg <= 8'h00;
      end
      else if (req && !busy_reg) begin
         busy_reg <= 1'b1;
         wait_reg <= LAT;
         we_reg <= we;
         addr_reg <= addr;
         wdata_reg <= wdata;
      end
      else if (busy_reg) begin
         wait_reg <= wait_reg - 4'h1;
         if (done) begin
            busy_reg <= 1'b0;
         end
      end
   end

   // RL3 write lands in target
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         function_address_reg <= uirp_pkg::REG_RESET;
         power_management_reg <= uirp_pkg::REG_RESET;
         in_enables_reg <= uirp_pkg::REG_RESET;
         out_enables_reg <= uirp_pkg::REG_RESET;
         common_enables_reg <= uirp_pkg::REG_RESET;
         endpoint_select_reg <= uirp_pkg::REG_RESET;
         clock_recovery_reg <= uirp_pkg::CLOCK_RECOVERY_RESET;
         ep_zero_csr_reg <= uirp_pkg::REG_RESET;
         for (int i = 0; i < 4; i++) begin
            in_lo_reg[i] <= uirp_pkg::REG_RESET;
            in_hi_reg[i] <= uirp_pkg::REG_RESET;
            out_lo_reg[i] <= uirp_pkg::REG_RESET;
            out_hi_reg[i] <= uirp_pkg::REG_RESET;
         end
      end
      else if (done && we_reg) begin
         case (sel)
            uirp_pkg::SEL_FUNCTION_ADDRESS_REG: function_address_reg <= wdata_reg;
            uirp_pkg::SEL_POWER: power_management_reg <= wdata_reg;
            uirp_pkg::SEL_IN_EN: in_enables_reg <= wdata_reg;
            uirp_pkg::SEL_OUT_EN: out_enables_reg <= wdata_reg;
            uirp_pkg::SEL_CM_EN: common_enables_reg <= wdata_reg;
            uirp_pkg::SEL_EP_SELECT: endpoint_select_reg <= {4'h0, wdata_reg[3:0]};
            uirp_pkg::SEL_CLOCK_RECOVERY_CONTROL: clock_recovery_reg <= wdata_reg;
            uirp_pkg::SEL_EP0_CSR: ep_zero_csr_reg <= wdata_reg;
            // RL10 indexed writes follow endpoint
            uirp_pkg::SEL_IN_CSR_LO: in_lo_reg[ep] <= wdata_reg;
            uirp_pkg::SEL_IN_CSR_HI: in_hi_reg[ep] <= wdata_reg;
            uirp_pkg::SEL_OUT_CSR_LO: out_lo_reg[ep] <= wdata_reg;
            uirp_pkg::SEL_OUT_CSR_HI: out_hi_reg[ep] <= wdata_reg;
            default: ;
         endcase
      end
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         in_csr_low_all[8*i +: 8] = in_lo_reg[i];
         in_csr_high_all[8*i +: 8] = in_hi_reg[i];
         out_csr_low_all[8*i +: 8] = out_lo_reg[i];
         out_csr_high_all[8*i +: 8] = out_hi_reg[i];
      end
   end

   // RL5 read result captured at completion
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rdata_reg <= uirp_pkg::DATA_PORT_RESET;
      end
      else if (done && !we_reg) begin
         case (sel)
            uirp_pkg::SEL_FUNCTION_ADDRESS_REG: rdata_reg <= function_address_reg;
            uirp_pkg::SEL_POWER: rdata_reg <= power_management_reg;
            uirp_pkg::SEL_IN_FLAGS: rdata_reg <= in_flags;
            uirp_pkg::SEL_OUT_FLAGS: rdata_reg <= out_flags;
            uirp_pkg::SEL_CM_FLAGS: rdata_reg <= common_flags;
            uirp_pkg::SEL_IN_EN: rdata_reg <= in_enables_reg;
            uirp_pkg::SEL_OUT_EN: rdata_reg <= out_enables_reg;
            uirp_pkg::SEL_CM_EN: rdata_reg <= common_enables_reg;
            uirp_pkg::SEL_FRAME_LO: rdata_reg <= frame_low;
            uirp_pkg::SEL_FRAME_HI: rdata_reg <= frame_high;
            uirp_pkg::SEL_EP_SELECT: rdata_reg <= endpoint_select_reg;
            uirp_pkg::SEL_CLOCK_RECOVERY_CONTROL: rdata_reg <= clock_recovery_reg;
            uirp_pkg::SEL_QUEUE: rdata_reg <= queue_rdata;
            uirp_pkg::SEL_EP0_CSR: rdata_reg <= ep_zero_csr_reg;
            uirp_pkg::SEL_IN_CSR_LO: rdata_reg <= in_lo_reg[ep];
            uirp_pkg::SEL_IN_CSR_HI: rdata_reg <= in_hi_reg[ep];
            uirp_pkg::SEL_OUT_CSR_LO: rdata_reg <= out_lo_reg[ep];
            uirp_pkg::SEL_OUT_CSR_HI: rdata_reg <= out_hi_reg[ep];
            uirp_pkg::SEL_EP0_COUNT: rdata_reg <= count_low_all[7:0];
            uirp_pkg::SEL_OUT_COUNT_LO: rdata_reg <= count_low_all[8*ep +: 8];
            uirp_pkg::SEL_OUT_COUNT_HI: rdata_reg <= count_high_all[8*ep +: 8];
            default: rdata_reg <= 8'h00;
         endcase
      end
   end

   // Queue strobes fire once per access so a read unloads one byte
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         queue_write <= 1'b0;
         queue_read <= 1'b0;
         queue_ep <= 2'd0;
         queue_wdata <= 8'h00;
      end
      else begin
         queue_write <= done && we_reg && (sel == uirp_pkg::SEL_QUEUE);
         queue_read <= done && !we_reg && (sel == uirp_pkg::SEL_QUEUE);
         if (done && (sel == uirp_pkg::SEL_QUEUE)) begin
            queue_ep <= addr_reg[1:0];
            queue_wdata <= wdata_reg;
         end
      end
   end
endmodule

// File: hw/uirp_port.sv
/*
 * Top of the indirect register port: address/control and data special
 * function registers, the busy handshake, and the internal register file.
 * Assumes the core drives one-cycle write strobes for each register and
 * polls busy before every access.
 */
`timescale 1ns/1ps
module uirp_port #(
   parameter int LATENCY = uirp_pkg::ACCESS_LATENCY
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic addr_sfr_write,
   input wire logic data_sfr_write,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] addr_sfr_rdata,
   output logic [7:0] data_sfr_rdata,
   input wire logic [7:0] in_flags,
   input wire logic [7:0] out_flags,
   input wire logic [7:0] common_flags,
   input wire logic [7:0] frame_low,
   input wire logic [7:0] frame_high,
   input wire logic [31:0] count_low_all,
   input wire logic [31:0] count_high_all,
   input wire logic [7:0] queue_rdata,
   output logic [7:0] function_address,
   output logic [7:0] power_management,
   output logic [7:0] in_enables,
   output logic [7:0] out_enables,
   output logic [7:0] common_enables,
   output logic [7:0] endpoint_select,
   output logic [7:0] clock_recovery,
   output logic [7:0] ep_zero_csr,
   output logic [31:0] in_csr_low_all,
   output logic [31:0] in_csr_high_all,
   output logic [31:0] out_csr_low_all,
   output logic [31:0] out_csr_high_all,
   output logic queue_write,
   output logic queue_read,
   output logic [1:0] queue_ep,
   output logic [7:0] queue_wdata
);
   localparam int MAX_WAIT = 16;

   uirp_pkg::uirp_state_e state_reg;
   logic [5:0] target_reg;
   logic [7:0] data_reg;
   logic req_reg;
   logic req_we_reg;
   logic rf_ack;
   logic [7:0] rf_rdata;
   logic busy;
   logic fetch_reg;
   logic idle_addr_write;
   logic idle_data_write;

   assign busy = (state_reg != uirp_pkg::ST_IDLE) || fetch_reg;
   // RL1 accesses while busy are dropped
   assign idle_addr_write = addr_sfr_write && !busy;
   assign idle_data_write = data_sfr_write && !busy;

   // Auto-read is not supported and reads back as zero
   assign addr_sfr_rdata = {busy, 1'b0, target_reg};
   assign data_sfr_rdata = data_reg;

   // RL11 busy until completion
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_reg <= uirp_pkg::ST_IDLE;
      end
      else begin
         case (state_reg)
            uirp_pkg::ST_IDLE: begin
               if (idle_data_write) begin
                  state_reg <= uirp_pkg::ST_WRITE;
               end
               else if (idle_addr_write && sfr_wdata[uirp_pkg::BUSY_BIT]) begin
                  state_reg <= uirp_pkg::ST_READ;
               end
            end
            uirp_pkg::ST_WRITE,
            uirp_pkg::ST_READ: begin
               if (rf_ack) begin
                  state_reg <= uirp_pkg::ST_IDLE;
               end
            end
            default: state_reg <= uirp_pkg::ST_IDLE;
         endcase
      end
   end

   // RL11 read result lands one cycle after ack
   // The file's read register is loaded on the ack edge, so busy must cover one more cycle
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         fetch_reg <= 1'b0;
      end
      else begin
         fetch_reg <= (state_reg == uirp_pkg::ST_READ) && rf_ack;
      end
   end

   // RL2 RL4 target select held
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         target_reg <= uirp_pkg::ADDR_REG_RESET[uirp_pkg::TARGET_MSB:0];
      end
      else if (idle_addr_write) begin
         target_reg <= sfr_wdata[uirp_pkg::TARGET_MSB:0];
      end
   end

   // RL3 RL5 data port contents
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         data_reg <= uirp_pkg::DATA_PORT_RESET;
      end
      else if (idle_data_write) begin
         data_reg <= sfr_wdata;
      end
      else if (fetch_reg) begin
         data_reg <= rf_rdata;
      end
   end

   // RL3 RL5 internal request issue
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         req_reg <= 1'b0;
         req_we_reg <= 1'b0;
      end
      else begin
         req_reg <= idle_data_write || (idle_addr_write && sfr_wdata[uirp_pkg::BUSY_BIT]);
         req_we_reg <= idle_data_write;
      end
   end

   uirp_reg_file #(
      .LATENCY(LATENCY)
   ) u_reg_file (
      .ref_clk(ref_clk),
      .srst(srst),
      .req(req_reg),
      .we(req_we_reg),
      .addr(target_reg),
      .wdata(data_reg),
      .ack(rf_ack),
      .rdata_reg(rf_rdata),
      .in_flags(in_flags),
      .out_flags(out_flags),
      .common_flags(common_flags),
      .frame_low(frame_low),
      .frame_high(frame_high),
      .count_low_all(count_low_all),
      .count_high_all(count_high_all),
      .queue_rdata(queue_rdata),
      .function_address_reg(function_address),
      .power_management_reg(power_management),
      .in_enables_reg(in_enables),
      .out_enables_reg(out_enables),
      .common_enables_reg(common_enables),
      .endpoint_select_reg(endpoint_select),
      .clock_recovery_reg(clock_recovery),
      .ep_zero_csr_reg(ep_zero_csr),
      .in_csr_low_all(in_csr_low_all),
      .in_csr_high_all(in_csr_high_all),
      .out_csr_low_all(out_csr_low_all),
      .out_csr_high_all(out_csr_high_all),
      .queue_write(queue_write),
      .queue_read(queue_read),
      .queue_ep(queue_ep),
      .queue_wdata(queue_wdata)
   );

   // Helper: cycles spent busy, bounds the wait
   logic [4:0] busy_cnt;
   always_ff @(posedge ref_clk) begin
      if (srst || !busy) begin
         busy_cnt <= 5'd0;
      end
      else if (busy_cnt != 5'd31) begin
         busy_cnt <= busy_cnt + 5'd1;
      end
   end

   sequence seq_write_start;
      data_sfr_write && !busy;
   endsequence

   sequence seq_read_start;
      addr_sfr_write && !busy && sfr_wdata[uirp_pkg::BUSY_BIT];
   endsequence

   a_write_sets_busy: assert property (@(posedge ref_clk) disable iff (srst) // RL3
      seq_write_start |=> busy && data_sfr_rdata == $past(sfr_wdata))
      else $error("Data port write did not start a busy write");

   a_write_forwarded: assert property (@(posedge ref_clk) disable iff (srst) // RL3
      seq_write_start |=> req_reg && req_we_reg ##1 !req_reg)
      else $error("Data port write not forwarded as one request");

   a_read_starts: assert property (@(posedge ref_clk) disable iff (srst) // RL5
      seq_read_start |=> busy && !req_we_reg && req_reg
      && target_reg == $past(sfr_wdata[uirp_pkg::TARGET_MSB:0]))
      else $error("Busy write did not start a read of the new target");

   a_read_result: assert property (@(posedge ref_clk) disable iff (srst) // RL5
      state_reg == uirp_pkg::ST_READ && rf_ack
      |=> busy ##1 !busy && data_sfr_rdata == $past(rf_rdata))
      else $error("Read result not in data port when busy fell");

   a_busy_holds: assert property (@(posedge ref_clk) disable iff (srst) // RL11
      state_reg != uirp_pkg::ST_IDLE && !rf_ack |=> busy)
      else $error("Busy dropped before the transfer completed");

   a_busy_bounded: assert property (@(posedge ref_clk) disable iff (srst) // RL11
      busy_cnt < 5'(MAX_WAIT))
      else $error("Indirect transfer never completed");

   a_ack_clears: assert property (@(posedge ref_clk) disable iff (srst) // RL11
      state_reg == uirp_pkg::ST_WRITE && rf_ack |=> !busy ##1 !rf_ack)
      else $error("Busy not cleared on completion");

   a_target_kept: assert property (@(posedge ref_clk) disable iff (srst) // RL4
      !addr_sfr_write |=> $stable(target_reg))
      else $error("Target select changed without an address write");

   a_busy_ignores: assert property (@(posedge ref_clk) disable iff (srst) // RL1
      busy && data_sfr_write && !fetch_reg |=> $stable(data_sfr_rdata))
      else $error("Data port changed by a write while busy");

   a_readback_busy: assert property (@(posedge ref_clk) disable iff (srst) // RL1
      seq_read_start |=> addr_sfr_rdata[uirp_pkg::BUSY_BIT])
      else $error("Busy bit not visible after read start");
endmodule

// File: verif/uirp_core_model.sv
/*
 * Model of the core on the special function register bus: polls busy and
 * runs indirect writes and reads with one-cycle strobes.
 * Assumes every task is entered at a falling edge of ref_clk.
 */
`timescale 1ns/1ps
module uirp_core_model (
   input wire logic ref_clk,
   input wire logic [7:0] addr_sfr_rdata,
   input wire logic [7:0] data_sfr_rdata,
   output logic addr_sfr_write = 1'b0,
   output logic data_sfr_write = 1'b0,
   output logic [7:0] sfr_wdata = 8'h00
);
   int hangs = 0;
   task automatic wait_idle();
      int n;
      n = 0;
      while (addr_sfr_rdata[7] !== 1'b0 && n < 40) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 40) hangs++;
   endtask
   task automatic strobe(input logic is_data, input logic [7:0] val, input bit poll);
      // Idle cycle first so a strobe never rises in the step that dropped the last
      @(negedge ref_clk);
      if (poll) wait_idle();
      sfr_wdata = val;
      addr_sfr_write = ~is_data;
      data_sfr_write = is_data;
      @(negedge ref_clk);
      addr_sfr_write = 1'b0;
      data_sfr_write = 1'b0;
      // Released bus must not appear to hold the last byte
      sfr_wdata = ~val;
   endtask
   task automatic write_reg(input logic [5:0] t, input logic [7:0] d);
      strobe(1'b0, {2'h0, t}, 1'b1);
      strobe(1'b1, d, 1'b1);
      wait_idle();
   endtask
   task automatic read_reg(input logic [5:0] t, output logic [7:0] d);
      strobe(1'b0, {2'h2, t}, 1'b1);
      wait_idle();
      d = data_sfr_rdata;
   endtask
endmodule

// File: verif/usb_indirect_register_port_tb.sv
/*
 * Self-checking bench of the indirect register port: a core model drives
 * the special function registers, a byte-array model predicts the written register values.
 * Assumes the port is built with the latency set here.
 */
`timescale 1ns/1ps
module usb_indirect_register_port_tb;
   localparam int LAT = 2;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic addr_sfr_write, data_sfr_write;
   logic [7:0] sfr_wdata, addr_sfr_rdata, data_sfr_rdata, queue_wdata, rd, d;
   logic [7:0] in_flags = 8'h00, out_flags = 8'h00, common_flags = 8'h00;
   logic [7:0] frame_low = 8'h00, frame_high = 8'h00, queue_rdata = 8'h00;
   logic [31:0] count_low_all = 32'h0, count_high_all = 32'h0;
   logic [7:0] function_address, power_management, in_enables, out_enables;
   logic [7:0] common_enables, endpoint_select, clock_recovery, ep_zero_csr;
   logic [31:0] in_csr_low_all, in_csr_high_all, out_csr_low_all, out_csr_high_all;
   logic queue_write, queue_read;
   logic [1:0] queue_ep;
   logic [9:0] q_last = 10'h000;
   logic [7:0] m [64];
   logic [5:0] rw [6] = '{6'h00, 6'h01, 6'h07, 6'h09, 6'h0b, 6'h0f};
   int fail_count = 0, num_checks = 0, n, q_writes = 0, q_reads = 0;

   always #10 ref_clk = ~ref_clk;

   uirp_port #(.LATENCY(LAT)) dut_u (.ref_clk, .srst, .addr_sfr_write, .data_sfr_write,
      .sfr_wdata, .addr_sfr_rdata, .data_sfr_rdata, .in_flags, .out_flags, .common_flags,
      .frame_low, .frame_high, .count_low_all, .count_high_all, .queue_rdata,
      .function_address, .power_management, .in_enables, .out_enables, .common_enables,
      .endpoint_select, .clock_recovery, .ep_zero_csr, .in_csr_low_all, .in_csr_high_all,
      .out_csr_low_all, .out_csr_high_all, .queue_write, .queue_read, .queue_ep,
      .queue_wdata);
   uirp_core_model core_u (.ref_clk, .addr_sfr_rdata, .data_sfr_rdata, .addr_sfr_write,
      .data_sfr_write, .sfr_wdata);

   always @(posedge ref_clk) begin
      if (queue_write === 1'b1) begin
         q_writes <= q_writes + 1;
         q_last <= {queue_ep, queue_wdata};
      end
      if (queue_read === 1'b1) q_reads <= q_reads + 1;
   end

   task automatic tally_and_finish();
      if (fail_count == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
      if (core_u.hangs != 0) begin
         fail_count++;
         tally_and_finish();
      end
   endtask
   task automatic rd_chk(input logic [5:0] t, input logic [7:0] exp);
      core_u.read_reg(t, rd);
      chk(rd, exp);
   endtask

   initial begin
      n = $urandom(63);
      repeat (8) @(negedge ref_clk);
      srst = 1'b0;
      chk(clock_recovery, 8'h09);
      chk(function_address, 8'h00);
      chk(addr_sfr_rdata, 8'h00);
      chk(data_sfr_rdata, 8'h00);
      foreach (rw[i]) begin
         m[rw[i]] = 8'($urandom);
         // Reserved low bits of clock recovery must be written as 01001
         if (rw[i] == 6'h0f) m[rw[i]][4:0] = 5'h09;
         core_u.write_reg(rw[i], m[rw[i]]);
         rd_chk(rw[i], m[rw[i]]);
      end
      chk(function_address, m[0]);
      chk(power_management, m[1]);
      chk(in_enables, m[7]);
      chk(out_enables, m[9]);
      chk(common_enables, m[11]);
      chk(clock_recovery, m[15]);
      {in_flags, out_flags, common_flags, frame_low, frame_high} = 40'({$urandom, $urandom});
      count_low_all = $urandom;
      count_high_all = $urandom;
      queue_rdata = 8'($urandom);
      rd_chk(6'h02, in_flags);
      rd_chk(6'h04, out_flags);
      rd_chk(6'h06, common_flags);
      rd_chk(6'h0c, frame_low);
      rd_chk(6'h0d, frame_high);
      core_u.write_reg(6'h00, 8'h5a);
      core_u.strobe(1'b1, 8'h3c, 1'b1);
      chk({7'h00, addr_sfr_rdata[7]}, 8'h01);
      core_u.strobe(1'b1, 8'hc3, 1'b0);
      n = 0;
      while (addr_sfr_rdata[7] !== 1'b0 && n < 40) begin
         @(negedge ref_clk);
         n++;
      end
      chk(8'(n), 8'(LAT - 1));
      chk(function_address, 8'h3c);
      for (int ep = 0; ep < 4; ep++) begin
         core_u.write_reg(6'h0e, 8'(ep));
         chk(endpoint_select, 8'(ep));
         rd_chk(6'h16, count_low_all[ep*8+:8]);
         d = 8'($urandom);
         if (ep == 0) m[17] = d;
         core_u.write_reg(6'h11, d);
         chk((ep == 0) ? ep_zero_csr : in_csr_low_all[ep*8+:8], d);
         rd_chk(6'h11, d);
         if (ep > 0) begin
            d = 8'($urandom);
            core_u.write_reg(6'h12, d);
            chk(in_csr_high_all[ep*8+:8], d);
            rd_chk(6'h17, count_high_all[ep*8+:8]);
            core_u.write_reg(6'h14, ~d);
            chk(out_csr_low_all[ep*8+:8], ~d);
            core_u.write_reg(6'h15, d ^ 8'h5a);
            rd_chk(6'h15, d ^ 8'h5a);
            chk(out_csr_high_all[ep*8+:8], d ^ 8'h5a);
         end else begin
            rd_chk(6'h12, 8'h00);
            core_u.write_reg(6'h14, 8'hff);
         end
      end
      chk(ep_zero_csr, m[17]);
      chk(out_csr_low_all[7:0], 8'h00);
      d = 8'($urandom);
      core_u.write_reg(6'h22, d);
      @(negedge ref_clk);
      chk(q_last[7:0], d);
      chk({6'h00, q_last[9:8]}, 8'h02);
      chk(8'(q_writes), 8'h01);
      rd_chk(6'h21, queue_rdata);
      chk(8'(q_reads), 8'h01);
      chk({6'h00, queue_ep}, 8'h01);
      tally_and_finish();
   end
endmodule
